// ==== jlo_lane_param_override.sv ====
// APB register bank overriding link lane identifiers and checksums, lanes 5 to 8
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns

// Overview of operation
// - lane 5 ident default 00101 unless forced
// - lane 6 ident default 00110 unless forced
// - lane 7 ident default 00111 unless forced
// - lane 8 ident default 01000 unless forced
// - lane 5 checksum computed unless forced
// - lane 6 checksum computed unless forced
// - lanes 7/8 forced checksums at 0x88
// - lanes 5/6 forced identifiers at 0x89
// - lanes 7/8 forced identifiers at 0x8a
// - enables act only while write select set
// - all fields clear to zero on reset
module jlo_lane_param_override #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // per-lane values to the transmitter, lane 5 first
  output jlo_pkg::jlo_lane_cfg_t lane5_cfg,
  output jlo_pkg::jlo_lane_cfg_t lane6_cfg,
  output jlo_pkg::jlo_lane_cfg_t lane7_cfg,
  output jlo_pkg::jlo_lane_cfg_t lane8_cfg,
  // computed checksums from the transmitter
  input wire logic [7:0] lane5_calc_fchk,
  input wire logic [7:0] lane6_calc_fchk,
  input wire logic [7:0] lane7_calc_fchk,
  input wire logic [7:0] lane8_calc_fchk
);

  // register state
  logic [15:0] ovr_en_q, ovr_en_d;
  logic [15:0] fchk56_q, fchk56_d;
  logic [15:0] fchk78_q, fchk78_d;
  logic [15:0] ident56_q, ident56_d;
  logic [15:0] ident78_q, ident78_d;
  logic wr_sel_q, wr_sel_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  jlo_pkg::jlo_lane_cfg_t l5_q, l5_d, l6_q, l6_d, l7_q, l7_d, l8_q, l8_d;

  logic [7:0] idx;
  logic aligned;
  logic access;
  logic mapped;
  logic [15:0] rd_val;
  logic [15:0] wmask;
  logic [3:0] id_en;
  logic [3:0] ck_en;

  // address decode: word index, low two bits must be zero
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  // setup cycle of a transfer; answered in the following access cycle
  assign access = psel && !penable;

  // read mux and mapped check
  always_comb
  begin
    mapped = aligned;
    rd_val = 16'h0000;
    unique case (idx)
      jlo_pkg::OVR_EN_IDX: rd_val = ovr_en_q;
      jlo_pkg::FCHK_56_IDX: rd_val = fchk56_q;
      jlo_pkg::FCHK_78_IDX: rd_val = fchk78_q;
      jlo_pkg::IDENT_56_IDX: rd_val = ident56_q;
      jlo_pkg::IDENT_78_IDX: rd_val = ident78_q;
      jlo_pkg::WR_SEL_IDX: rd_val = 16'(wr_sel_q) << jlo_pkg::WR_SEL_BIT;
      default: mapped = 1'b0;
    endcase
    if (!aligned)
    begin
      rd_val = 16'h0000;
    end
  end

  // byte lane mask from the two low strobes
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // write lands only at the edge that completes the access phase
  logic wr_commit;
  assign wr_commit = psel && penable && pready_q && pwrite && mapped;

  // bus answer: one access cycle after each setup
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (access)
    begin
      pready_d = 1'b1;
      pslverr_d = !mapped;
      if (!pwrite && mapped)
      begin
        prdata_d = {16'h0000, rd_val};
      end
    end
  end

  // bus answer flops, idle after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // enable register: reserved low byte held at zero
  always_comb
  begin
    ovr_en_d = ovr_en_q;
    if (wr_commit && (idx == jlo_pkg::OVR_EN_IDX))
    begin
      ovr_en_d = (ovr_en_q & ~wmask) | (pwdata[15:0] & wmask & jlo_pkg::OVR_EN_MASK);
    end
  end

  // enable register flops; stored even while the select is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovr_en_q <= jlo_pkg::REG_RESET;
    end
    else
    begin
      ovr_en_q <= ovr_en_d;
    end
  end

  // lane 5 and 6 forced checksums, full bytes
  always_comb
  begin
    fchk56_d = fchk56_q;
    if (wr_commit && (idx == jlo_pkg::FCHK_56_IDX))
    begin
      fchk56_d = (fchk56_q & ~wmask) | (pwdata[15:0] & wmask);
    end
  end

  // lane 5 and 6 checksum flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fchk56_q <= jlo_pkg::REG_RESET;
    end
    else
    begin
      fchk56_q <= fchk56_d;
    end
  end

  // lane 7 and 8 forced checksums, full bytes
  always_comb
  begin
    fchk78_d = fchk78_q;
    if (wr_commit && (idx == jlo_pkg::FCHK_78_IDX))
    begin
      fchk78_d = (fchk78_q & ~wmask) | (pwdata[15:0] & wmask);
    end
  end

  // lane 7 and 8 checksum flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fchk78_q <= jlo_pkg::REG_RESET;
    end
    else
    begin
      fchk78_q <= fchk78_d;
    end
  end

  // lane 5 and 6 forced identifiers, reserved bits kept zero
  always_comb
  begin
    ident56_d = ident56_q;
    if (wr_commit && (idx == jlo_pkg::IDENT_56_IDX))
    begin
      ident56_d = (ident56_q & ~wmask) | (pwdata[15:0] & wmask & jlo_pkg::IDENT_MASK);
    end
  end

  // lane 5 and 6 identifier flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ident56_q <= jlo_pkg::REG_RESET;
    end
    else
    begin
      ident56_q <= ident56_d;
    end
  end

  // lane 7 and 8 forced identifiers, reserved bits kept zero
  always_comb
  begin
    ident78_d = ident78_q;
    if (wr_commit && (idx == jlo_pkg::IDENT_78_IDX))
    begin
      ident78_d = (ident78_q & ~wmask) | (pwdata[15:0] & wmask & jlo_pkg::IDENT_MASK);
    end
  end

  // lane 7 and 8 identifier flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ident78_q <= jlo_pkg::REG_RESET;
    end
    else
    begin
      ident78_q <= ident78_d;
    end
  end

  // serial link write select, low byte strobe only
  always_comb
  begin
    wr_sel_d = wr_sel_q;
    if (wr_commit && (idx == jlo_pkg::WR_SEL_IDX) && pstrb[0])
    begin
      wr_sel_d = pwdata[jlo_pkg::WR_SEL_BIT];
    end
  end

  // write select flop; off after reset so enables wait for it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_sel_q <= 1'b0;
    end
    else
    begin
      wr_sel_q <= wr_sel_d;
    end
  end

  // enables gated by the serial link write select
  always_comb
  begin
    for (int i = 0; i < jlo_pkg::NUM_LANES; i++)
    begin
      id_en[i] = wr_sel_q && ovr_en_q[jlo_pkg::IDENT_EN_HI_BIT - i];
      ck_en[i] = wr_sel_q && ovr_en_q[jlo_pkg::FCHK_EN_HI_BIT - i];
    end
  end

  // per-lane selection of identifier and checksum
  always_comb
  begin
    l5_d.ident = id_en[0] ? ident56_q[12:8] : jlo_pkg::LANE5_DEFAULT_IDENT;
    l6_d.ident = id_en[1] ? ident56_q[4:0] : jlo_pkg::LANE6_DEFAULT_IDENT;
    l7_d.ident = id_en[2] ? ident78_q[12:8] : jlo_pkg::LANE7_DEFAULT_IDENT;
    l8_d.ident = id_en[3] ? ident78_q[4:0] : jlo_pkg::LANE8_DEFAULT_IDENT;
    l5_d.fchk_forced = ck_en[0];
    l6_d.fchk_forced = ck_en[1];
    l7_d.fchk_forced = ck_en[2];
    l8_d.fchk_forced = ck_en[3];
    l5_d.fchk = ck_en[0] ? fchk56_q[15:8] : lane5_calc_fchk;
    l6_d.fchk = ck_en[1] ? fchk56_q[7:0] : lane6_calc_fchk;
    l7_d.fchk = ck_en[2] ? fchk78_q[15:8] : lane7_calc_fchk;
    l8_d.fchk = ck_en[3] ? fchk78_q[7:0] : lane8_calc_fchk;
  end

  // lane value flops; defaults and no forcing during reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      l5_q <= '{ident: jlo_pkg::LANE5_DEFAULT_IDENT, fchk_forced: 1'b0, fchk: 8'h00};
      l6_q <= '{ident: jlo_pkg::LANE6_DEFAULT_IDENT, fchk_forced: 1'b0, fchk: 8'h00};
      l7_q <= '{ident: jlo_pkg::LANE7_DEFAULT_IDENT, fchk_forced: 1'b0, fchk: 8'h00};
      l8_q <= '{ident: jlo_pkg::LANE8_DEFAULT_IDENT, fchk_forced: 1'b0, fchk: 8'h00};
    end
    else
    begin
      // one cycle of latency on the computed checksum path
      l5_q <= l5_d;
      l6_q <= l6_d;
      l7_q <= l7_d;
      l8_q <= l8_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lane5_cfg = l5_q;
  assign lane6_cfg = l6_q;
  assign lane7_cfg = l7_q;
  assign lane8_cfg = l8_q;

endmodule : jlo_lane_param_override

// ==== jlo_pkg.sv ====
// package for the lane 5 to 8 link parameter override bank
package jlo_pkg;

  // register offsets (printed offsets not multiples of four: index, byte = 4 x index)
  localparam logic [7:0] OVR_EN_IDX = 8'h86;
  localparam logic [7:0] FCHK_56_IDX = 8'h87;
  localparam logic [7:0] FCHK_78_IDX = 8'h88;
  localparam logic [7:0] IDENT_56_IDX = 8'h89;
  localparam logic [7:0] IDENT_78_IDX = 8'h8A;
  // own control register carrying the serial link write select
  localparam logic [7:0] WR_SEL_IDX = 8'h03;
  localparam int WR_SEL_BIT = 5;

  // field positions
  localparam int IDENT_EN_HI_BIT = 15;
  localparam int FCHK_EN_HI_BIT = 11;
  localparam int HI_FIELD_LSB = 8;
  localparam int LO_FIELD_LSB = 0;
  localparam int IDENT_W = 5;
  localparam int FCHK_W = 8;
  localparam int NUM_LANES = 4;

  // reset value and write masks
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] OVR_EN_MASK = 16'hFF00;
  localparam logic [15:0] IDENT_MASK = 16'h1F1F;

  // default lane identifiers
  localparam logic [4:0] LANE5_DEFAULT_IDENT = 5'h05;
  localparam logic [4:0] LANE6_DEFAULT_IDENT = 5'h06;
  localparam logic [4:0] LANE7_DEFAULT_IDENT = 5'h07;
  localparam logic [4:0] LANE8_DEFAULT_IDENT = 5'h08;

  // per-lane value presented to the transmitter
  typedef struct packed {
    logic [4:0] ident;
    logic fchk_forced;
    logic [7:0] fchk;
  } jlo_lane_cfg_t;

endpackage : jlo_pkg

// ==== jlo_tx_model.sv ====
// far-side model giving the computed lane checksums
`timescale 1ns/1ns
module jlo_tx_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // computed checksums, lane 5 first
  output logic [7:0] calc [4]
);
  // new value every cycle so a stale pass-through shows
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        calc[i] <= 8'h5A + 8'(i);
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        calc[i] <= calc[i] + 8'h1D + 8'(i);
    end
  end
endmodule : jlo_tx_model

// ==== jlo_sva.sv ====
// assertions on the lane override bank ports
`timescale 1ns/1ns
module jlo_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // lanes 5 and 6
  input wire jlo_pkg::jlo_lane_cfg_t lane5_cfg,
  input wire jlo_pkg::jlo_lane_cfg_t lane6_cfg,
  input wire logic [7:0] lane5_calc_fchk,
  input wire logic [7:0] lane6_calc_fchk
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // answer timing
  rdy_one_a: assert property (pready |=> !pready) else $error("pready held");
  setup_ans_a: assert property (psel && !penable |=> pready) else $error("no answer");
  err_rdy_a: assert property (pslverr |-> pready) else $error("error without ready");
  // unforced checksums pass through one cycle late
  fchk5_pass_a: assert property ($past(presetn) && !lane5_cfg.fchk_forced
    |-> lane5_cfg.fchk == $past(lane5_calc_fchk)) else $error("lane5 checksum");
  fchk6_pass_a: assert property ($past(presetn) && !lane6_cfg.fchk_forced
    |-> lane6_cfg.fchk == $past(lane6_calc_fchk)) else $error("lane6 checksum");
  // reserved ident bits read zero
  id56_rsv_a: assert property (pready && !pwrite && paddr == 12'h224
    |-> (prdata & ~32'h00001F1F) == 32'h0) else $error("ident56 reserved");
  id78_rsv_a: assert property (pready && !pwrite && paddr == 12'h228
    |-> (prdata & ~32'h00001F1F) == 32'h0) else $error("ident78 reserved");
  // defaults right after reset
  rst_dflt_a: assert property ($rose(presetn) |-> !lane5_cfg.fchk_forced
    && lane5_cfg.ident == jlo_pkg::LANE5_DEFAULT_IDENT) else $error("reset defaults");
endmodule : jlo_sva
bind jlo_lane_param_override jlo_sva jlo_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .lane5_cfg(lane5_cfg), .lane6_cfg(lane6_cfg),
  .lane5_calc_fchk(lane5_calc_fchk), .lane6_calc_fchk(lane6_calc_fchk));

// ==== tb_jlo_lane_param_override.sv ====
// self-checking bench for the lane override bank
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb_jlo_lane_param_override;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire jlo_pkg::jlo_lane_cfg_t cfg [4];
  wire [7:0] calc [4];
  logic [7:0] c_q [4];
  logic [7:0] fck [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
  logic [4:0] fid [4] = '{5'h1A, 5'h0B, 5'h15, 5'h03};
  logic [15:0] ex [5] = '{16'hFF00, 16'hA55A, 16'h3CC3, 16'h1A0B, 16'h1503};
  logic [15:0] mk [5] = '{16'hFF00, 16'hFFFF, 16'hFFFF, 16'h1F1F, 16'h1F1F};
  int mismatches = 0;
  int n_checks = 0;
  jlo_lane_param_override jlo_lane_param_override_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lane5_cfg(cfg[0]),
    .lane6_cfg(cfg[1]), .lane7_cfg(cfg[2]), .lane8_cfg(cfg[3]), .lane5_calc_fchk(calc[0]),
    .lane6_calc_fchk(calc[1]), .lane7_calc_fchk(calc[2]), .lane8_calc_fchk(calc[3]));
  jlo_tx_model jlo_tx_model_i (.pclk(pclk), .presetn(presetn), .calc(calc));
  // clock and last computed checksums
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) c_q <= calc;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  function automatic logic [11:0] ba(input int i);
    return {2'b00, jlo_pkg::OVR_EN_IDX + 8'(i), 2'b00};
  endfunction : ba
  // one apb transfer, bounded wait for pready
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d,
    input logic [15:0] x, input logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      mismatches++;
      end_of_test();
    end
    `CHK(pslverr, e)
    if (!w)
      `CHK(prdata, {16'h0000, x})
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : acc
  // lane outputs against select s and enables en
  task automatic lanes(input logic s, input logic [15:0] en);
    logic f;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      f = s & en[11-i];
      `CHK(cfg[i].ident, (s & en[15-i]) ? fid[i] : 5'(5 + i))
      `CHK(cfg[i].fchk_forced, f)
      `CHK(cfg[i].fchk, f ? fck[i] : c_q[i])
    end
  endtask : lanes
  // main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      lanes(1'b0, 16'h0000);
      for (int i = 0; i < 5; i++)
        acc(1'b0, ba(i), 16'h0000, 16'h0000, 1'b0);
      if (r == 0)
      begin
        for (int i = 0; i < 5; i++)
          acc(1'b1, ba(i), mk[i], 16'h0000, 1'b0);
        for (int i = 0; i < 5; i++)
          acc(1'b0, ba(i), 16'h0000, mk[i], 1'b0);
        lanes(1'b0, 16'hFF00);
        for (int i = 0; i < 5; i++)
          acc(1'b1, ba(i), ex[i], 16'h0000, 1'b0);
        for (int i = 0; i < 5; i++)
          acc(1'b0, ba(i), 16'h0000, ex[i], 1'b0);
        pstrb <= 4'h2;
        acc(1'b1, ba(1), 16'h0000, 16'h0000, 1'b0);
        pstrb <= 4'hF;
        acc(1'b0, ba(1), 16'h0000, 16'h005A, 1'b0);
        acc(1'b1, ba(1), 16'hA55A, 16'h0000, 1'b0);
        acc(1'b1, 12'h00C, 16'h0020, 16'h0000, 1'b0);
        acc(1'b0, 12'h00C, 16'h0000, 16'h0020, 1'b0);
        lanes(1'b1, 16'hFF00);
        acc(1'b1, ba(0), 16'h5500, 16'h0000, 1'b0);
        lanes(1'b1, 16'h5500);
        acc(1'b1, ba(0), 16'hAA00, 16'h0000, 1'b0);
        lanes(1'b1, 16'hAA00);
        acc(1'b1, 12'h00C, 16'h0000, 16'h0000, 1'b0);
        lanes(1'b0, 16'hAA00);
        acc(1'b0, 12'h230, 16'h0000, 16'h0000, 1'b1);
        acc(1'b0, 12'h219, 16'h0000, 16'h0000, 1'b1);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
      end
    end
    end_of_test();
  end
endmodule : tb_jlo_lane_param_override
